// ==== bench/pll_control_port_logic_tb.sv ====
// Self-checking bench: controller and loop joined by the link, run over the register port.
// Assumes the controller register map and constants of the shared package.
`timescale 1ns/1ps
module pll_control_port_logic_tb;
    import pll_ctl_pkg::*;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic ref_pin = 1'b0;
    logic ref_run = 1'b1;
    logic [ADDR_W-1:0] addr = '0;
    logic [31:0] wdata = '0;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic [31:0] rdata;
    logic irq;
    logic dres_n;
    logic logic_clock;
    logic [CORE_OUTS-1:0] global_clock;
    logic board_pin;
    logic [31:0] got;
    logic [31:0] hold_ctrl [2] = '{32'h4, 32'h7};
    int n_mismatch = 0;
    int checks_done = 0;
    int ref_half = 8;
    int ref_cnt = 0;
    int highs;
    int clk_highs;
    pll_link_if link();
    always #4 sys_clk = ~sys_clk;
    // Reference stops entirely when frozen, to show the outputs do not follow it
    always @(posedge sys_clk) begin
        ref_cnt <= (ref_cnt >= ref_half - 1) ? 0 : ref_cnt + 1;
        if (ref_run && ref_cnt >= ref_half - 1) begin
            ref_pin <= ~ref_pin;
        end
    end
    pll_loop u_pll_loop (.SYS_CLK(sys_clk), .RSTN(rstn), .LINK(link.loop),
        .GLOBAL_CLOCK(global_clock), .BOARD_CLOCK_PIN(board_pin));
    pll_controller u_pll_controller (.SYS_CLK(sys_clk), .RSTN(rstn), .REF_CLOCK_PIN(ref_pin),
        .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s), .RDATA(rdata), .IRQ(irq),
        .DOWNSTREAM_RSTN(dres_n), .LOGIC_CLOCK(logic_clock), .LINK(link.controller));
    pll_ctl_checker u_pll_ctl_checker (.SYS_CLK(sys_clk), .RSTN(rstn),
        .reference_clock_in(link.reference_clock_in), .loop_enable(link.loop_enable),
        .counter_clear(link.counter_clear), .pd_enable(link.pd_enable),
        .core_clock(link.core_clock), .external_clock_output(link.external_clock_output),
        .lock(link.lock));
    function automatic logic [31:0] status_exp(input logic stable, input logic lk);
        return {29'h0, !stable, stable, lk};
    endfunction : status_exp
    task automatic check(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : check
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        wr_s <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge sys_clk);
        wr_s <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        rd_s <= 1'b1;
        addr <= a;
        @(posedge sys_clk);
        rd_s <= 1'b0;
        #1;
        d = rdata;
    endtask : rd
    // Bounded wait on lock (0) or released downstream reset (1)
    task automatic wait_for(input bit sel);
        int i;
        i = 0;
        while ((sel ? dres_n : link.lock) !== 1'b1 && i < 4000) begin
            @(posedge sys_clk);
            #1;
            i++;
        end
    endtask : wait_for
    task automatic give_verdict();
        $display("mismatches %0d, checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (60000) @(posedge sys_clk);
        n_mismatch++;
        give_verdict();
    end
    initial begin
        void'($urandom(32'h01178fb5));
        ref_half = 6 + $urandom_range(6);
        repeat (12) @(posedge sys_clk);
        rstn <= 1'b1;
        rd(CTRL_ADDR, got);
        check(got, {29'h0, CTRL_RESET});
        rd(STABLE_REFS_ADDR, got);
        check(got, {16'h0, STABLE_REFS_RESET});
        rd(8'h14, got);
        check(got, 32'h0);
        check(dres_n, 1'b0);
        wr(STABLE_REFS_ADDR, 32'h2 + $urandom_range(3));
        wr(INT_MASK_ADDR, 32'h3);
        rd(INT_MASK_ADDR, got);
        check(got, 32'h3);
        wait_for(1'b0);
        check(link.lock, 1'b1);
        wait_for(1'b1);
        check(irq, 1'b1);
        rd(STATUS_ADDR, got);
        check(got, status_exp(1'b1, 1'b1));
        rd(INT_STATUS_ADDR, got);
        check({got, irq}, {32'h1, 1'b0});
        ref_run <= 1'b0;
        wr(CTRL_ADDR, 32'h1);
        highs = 0;
        clk_highs = 0;
        repeat (100) begin
            @(posedge sys_clk);
            #1;
            highs += board_pin;
            clk_highs += logic_clock;
        end
        check(highs > 30 && highs < 70, 1'b1);
        check(clk_highs > 30 && clk_highs < 70, 1'b1);
        ref_run <= 1'b1;
        wr(CTRL_ADDR, 32'h5);
        // The long gap in the reference breaks lock; wait 80 cycles for the loss, then for the downstream reset release
        repeat (80) @(posedge sys_clk);
        wait_for(1'b1);
        check(dres_n, 1'b1);
        rd(INT_STATUS_ADDR, got);
        foreach (hold_ctrl[i]) begin
            wr(CTRL_ADDR, hold_ctrl[i]);
            repeat (3) @(posedge sys_clk);
            #1;
            check({global_clock, board_pin, link.lock, dres_n, irq}, 6'h01);
            rd(STATUS_ADDR, got);
            check(got, status_exp(1'b0, 1'b0));
            wr(INT_MASK_ADDR, 32'h0);
            check(irq, 1'b0);
            rd(INT_STATUS_ADDR, got);
            check(got, 32'h2);
            wr(INT_MASK_ADDR, 32'h3);
            wr(CTRL_ADDR, 32'h5);
            wait_for(1'b1);
            check(dres_n, 1'b1);
            rd(INT_STATUS_ADDR, got);
            repeat (60) @(posedge sys_clk);
        end
        give_verdict();
    end
endmodule : pll_control_port_logic_tb

// ==== bench/pll_ctl_checker.sv ====
// Concurrent checks on the link between loop and controller.
// Assumes one clock domain and an instance beside the link in the bench.
`timescale 1ns/1ps
module pll_ctl_checker
    import pll_ctl_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RSTN,
    input wire logic reference_clock_in,
    input wire logic loop_enable,
    input wire logic counter_clear,
    input wire logic pd_enable,
    input wire logic [CORE_OUTS-1:0] core_clock,
    input wire logic external_clock_output,
    input wire logic lock
);
    logic hold;
    logic run;
    assign hold = !loop_enable || counter_clear;
    assign run = !hold;
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RSTN);
    AST_EN_LOW: assert property (!loop_enable |=> core_clock == '0 && !external_clock_output)
        else $error("clock output live while disabled");
    AST_CLR_HIGH: assert property (counter_clear |=> core_clock == '0 && !lock)
        else $error("output or lock live during clear");
    AST_HOLD_IDLE: assert property (hold [*2] |-> core_clock == '0 && !lock)
        else $error("loop not held in reset");
    AST_RESTART: assert property ($fell(hold) |-> !lock [*8])
        else $error("lock without fresh acquisition");
    AST_EXT_COPY: assert property (external_clock_output == core_clock[0])
        else $error("board clock differs from core clock");
    AST_PD_RUNS: assert property (!pd_enable && lock |-> ##[1:40] $changed(core_clock[0]))
        else $error("oscillator stopped with detector off");
    AST_LOCK_RISE: assert property ($rose(lock) |-> $past(run) && $past(run, 2))
        else $error("lock rose while held");
    AST_LOCK_RUN: assert property (lock |-> $past(run))
        else $error("lock high after hold");
    AST_DIV_EDGE: assert property ($changed(core_clock[1]) |-> $changed(core_clock[0]) || $past(hold))
        else $error("divided clock moved alone");
endmodule : pll_ctl_checker

// ==== hdl/pll_controller.sv ====
// Controller that drives the loop controls from software registers and
// qualifies lock before releasing reset to downstream logic.
// Assumes a single-cycle register port and a reference from a dedicated pin.
`timescale 1ns/1ps
module pll_controller
    import pll_ctl_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RSTN,
    input wire logic REF_CLOCK_PIN,
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    output logic IRQ,
    output logic DOWNSTREAM_RSTN,
    output logic LOGIC_CLOCK,
    pll_link_if.controller LINK
);
    logic [2:0] ctrl_q;
    logic [EV_W-1:0] int_status_q;
    logic [EV_W-1:0] int_mask_q;
    logic [STABLE_W-1:0] stable_refs_q;
    logic [STABLE_W-1:0] stable_cnt_q;
    logic stable_q;
    logic ref_q;
    logic [31:0] rdata_q;
    logic [EV_W-1:0] events;
    logic stable_d;

    assign stable_d = LINK.lock && ctrl_q[CTRL_ENABLE_BIT] && !ctrl_q[CTRL_CLEAR_BIT]
        && (stable_cnt_q >= stable_refs_q);
    assign events[EV_STABLE_BIT] = stable_d && !stable_q;
    assign events[EV_LOST_BIT] = !stable_d && stable_q;

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            ctrl_q <= CTRL_RESET;
            int_mask_q <= '0;
            stable_refs_q <= STABLE_REFS_RESET;
        end else if (WR) begin
            case (ADDR)
                CTRL_ADDR: ctrl_q <= WDATA[2:0];
                INT_MASK_ADDR: int_mask_q <= WDATA[EV_W-1:0];
                STABLE_REFS_ADDR: stable_refs_q <= WDATA[STABLE_W-1:0];
                default: ctrl_q <= ctrl_q;
            endcase
        end
    end

    // Lock may toggle during acquisition, so only an unbroken run counts
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            ref_q <= 1'b0;
            stable_cnt_q <= '0;
            stable_q <= 1'b0;
        end else begin
            ref_q <= REF_CLOCK_PIN;
            stable_q <= stable_d;
            if (!LINK.lock || !ctrl_q[CTRL_ENABLE_BIT] || ctrl_q[CTRL_CLEAR_BIT]) begin
                stable_cnt_q <= '0;
            end else if (REF_CLOCK_PIN && !ref_q && stable_cnt_q != {STABLE_W{1'b1}}) begin
                stable_cnt_q <= stable_cnt_q + 16'h0001;
            end
        end
    end

    // A read clears the status, but an event in the same cycle survives
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            int_status_q <= '0;
        end else if (RD && ADDR == INT_STATUS_ADDR) begin
            int_status_q <= events;
        end else begin
            int_status_q <= int_status_q | events;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            rdata_q <= '0;
        end else if (RD) begin
            case (ADDR)
                CTRL_ADDR: rdata_q <= {29'h0, ctrl_q};
                STATUS_ADDR: rdata_q <= {29'h0, !stable_q, stable_q, LINK.lock};
                INT_STATUS_ADDR: rdata_q <= {30'h0, int_status_q};
                INT_MASK_ADDR: rdata_q <= {30'h0, int_mask_q};
                STABLE_REFS_ADDR: rdata_q <= {16'h0, stable_refs_q};
                default: rdata_q <= '0;
            endcase
        end else begin
            rdata_q <= '0;
        end
    end

    assign RDATA = rdata_q;
    assign IRQ = |(int_status_q & int_mask_q);
    assign DOWNSTREAM_RSTN = stable_q;
    assign LOGIC_CLOCK = LINK.core_clock[0];
    assign LINK.reference_clock_in = REF_CLOCK_PIN;
    assign LINK.loop_enable = ctrl_q[CTRL_ENABLE_BIT];
    assign LINK.counter_clear = ctrl_q[CTRL_CLEAR_BIT];
    assign LINK.pd_enable = ctrl_q[CTRL_PD_BIT];

endmodule : pll_controller

// ==== hdl/pll_loop.sv ====
// Digital model of the loop: oscillator, phase detector and lock indicator.
// Assumes the reference is sampled on SYS_CLK and is much slower than it.
//
// How it works
// - Enable high runs loop; low holds reset
// - Enable low grounds clocks, drops lock
// - Enable rising restarts acquisition on reference
// - Counter clear resets counters, outputs, lock
// - Clear falling restarts acquisition on reference
// - Detector off suppresses up/down, oscillator runs
// - Detector off: clocks free-run, may drift
// - Lock output high locked, low otherwise
// - Lock consumers tolerate toggling during acquisition
// - Reference only from dedicated clock pins
// - At least one loop output used
// - Core clocks global, external clock to pins
// - Controls may come from fabric or pins
//
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module pll_loop
    import pll_ctl_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RSTN,
    pll_link_if.loop LINK,
    output logic [CORE_OUTS-1:0] GLOBAL_CLOCK,
    output logic BOARD_CLOCK_PIN
);
    loop_state_type state_q;
    loop_state_type state_d;
    logic ref_q;
    logic ref_rise;
    logic hold;
    logic [PERIOD_W-1:0] ref_cnt_q;
    logic [PERIOD_W-1:0] ref_period_q;
    logic period_valid_q;
    logic [PERIOD_W-1:0] half_q;
    logic [PERIOD_W-1:0] osc_cnt_q;
    logic osc_q;
    logic osc_div_q;
    logic pd_up;
    logic pd_down;
    logic [PERIOD_W-1:0] osc_period;
    logic in_tol;
    logic [LOCK_CNT_W-1:0] good_q;
    logic lock_q;
    logic [CORE_OUTS-1:0] core_q;
    logic ext_q;

    // Enable low or clear high both hold the whole loop at its start values
    assign hold = !LINK.loop_enable || LINK.counter_clear;
    assign ref_rise = LINK.reference_clock_in && !ref_q;
    assign osc_period = {half_q[PERIOD_W-2:0], 1'b0};
    assign in_tol = abs_diff(osc_period, ref_period_q) <= LOCK_TOL;

    // Phase detector compares one oscillator period against the measured reference
    // period at every reference edge; with the detector disabled both outputs stay low.
    assign pd_up = LINK.pd_enable && ref_rise && period_valid_q
        && (osc_period > ref_period_q);
    assign pd_down = LINK.pd_enable && ref_rise && period_valid_q
        && (osc_period < ref_period_q) && (half_q > HALF_MIN);

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            ref_q <= 1'b0;
        end else begin
            ref_q <= LINK.reference_clock_in;
        end
    end

    always_comb begin
        state_d = state_q;
        case (state_q)
            LOOP_HOLD: begin
                if (!hold) begin
                    state_d = LOOP_WAIT_REF;
                end
            end
            LOOP_WAIT_REF: begin
                if (ref_rise) begin
                    state_d = LOOP_ACQUIRE;
                end
            end
            LOOP_ACQUIRE: begin
                if (ref_rise && in_tol && period_valid_q && good_q == LOCK_REFS) begin
                    state_d = LOOP_LOCKED;
                end
            end
            LOOP_LOCKED: begin
                if (ref_rise && !in_tol) begin
                    state_d = LOOP_ACQUIRE;
                end
            end
            default: begin
                state_d = LOOP_HOLD;
            end
        endcase
        if (hold) begin
            state_d = LOOP_HOLD;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            state_q <= LOOP_HOLD;
        end else begin
            state_q <= state_d;
        end
    end

    // Reference period measurement, restarted on each reference edge
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            ref_cnt_q <= '0;
            ref_period_q <= '0;
            period_valid_q <= 1'b0;
        end else if (state_d == LOOP_HOLD || state_q == LOOP_HOLD) begin
            ref_cnt_q <= '0;
            ref_period_q <= '0;
            period_valid_q <= 1'b0;
        end else if (ref_rise) begin
            ref_cnt_q <= 16'h0001;
            if (state_q != LOOP_WAIT_REF) begin
                ref_period_q <= ref_cnt_q;
                period_valid_q <= 1'b1;
            end
        end else if (ref_cnt_q != PERIOD_MAX) begin
            ref_cnt_q <= ref_cnt_q + 16'h0001;
        end
    end

    // Oscillator tuning; the last tuned value is kept while the detector is off,
    // so frequency only drifts by whatever the tuning word was last off by.
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            half_q <= HALF_INIT;
        end else if (state_q == LOOP_HOLD) begin
            half_q <= HALF_INIT;
        end else if (pd_down) begin
            half_q <= half_q + 16'h0001;
        end else if (pd_up) begin
            half_q <= half_q - 16'h0001;
        end
    end

    // Oscillator runs from the first reference edge after release and then
    // keeps toggling whether or not the reference still arrives.
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            osc_cnt_q <= '0;
            osc_q <= 1'b0;
            osc_div_q <= 1'b0;
        end else if (state_q == LOOP_HOLD || state_q == LOOP_WAIT_REF) begin
            osc_cnt_q <= '0;
            osc_q <= 1'b0;
            osc_div_q <= 1'b0;
        end else if (osc_cnt_q + 16'h0001 >= half_q) begin
            osc_cnt_q <= '0;
            osc_q <= !osc_q;
            if (osc_q) begin
                osc_div_q <= !osc_div_q;
            end
        end else begin
            osc_cnt_q <= osc_cnt_q + 16'h0001;
        end
    end

    // Lock qualifier: consecutive reference edges inside tolerance
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            good_q <= '0;
        end else if (state_q == LOOP_HOLD) begin
            good_q <= '0;
        end else if (ref_rise) begin
            if (!(in_tol && period_valid_q)) begin
                good_q <= '0;
            end else if (good_q != LOCK_REFS) begin
                good_q <= good_q + 4'h1;
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            lock_q <= 1'b0;
        end else begin
            lock_q <= (state_d == LOOP_LOCKED);
        end
    end

    // Outputs are registered and grounded whenever the loop is held
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            core_q <= '0;
            ext_q <= 1'b0;
        end else if (hold) begin
            core_q <= '0;
            ext_q <= 1'b0;
        end else begin
            core_q <= {osc_div_q, osc_q};
            ext_q <= osc_q;
        end
    end

    assign LINK.core_clock = core_q;
    assign LINK.external_clock_output = ext_q;
    assign LINK.lock = lock_q;
    assign GLOBAL_CLOCK = core_q;
    assign BOARD_CLOCK_PIN = ext_q;

endmodule : pll_loop

// ==== shared/pll_ctl_pkg.sv ====
// Constants and types shared by the loop model and its controller.
// Assumes one system clock at 125 MHz; the reference arrives as a synchronous level.
package pll_ctl_pkg;
    localparam int CLK_PERIOD_NS = 8;
    localparam int PERIOD_W = 16;
    localparam logic [PERIOD_W-1:0] HALF_INIT = 16'h0004;
    localparam logic [PERIOD_W-1:0] HALF_MIN = 16'h0001;
    localparam logic [PERIOD_W-1:0] PERIOD_MAX = 16'hffff;
    localparam logic [PERIOD_W-1:0] LOCK_TOL = 16'h0001;
    localparam int LOCK_CNT_W = 4;
    localparam logic [LOCK_CNT_W-1:0] LOCK_REFS = 4'h4;
    localparam int CORE_OUTS = 2;

    // Controller register map, byte addresses
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] CTRL_ADDR = 8'h00;
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h04;
    localparam logic [ADDR_W-1:0] INT_STATUS_ADDR = 8'h08;
    localparam logic [ADDR_W-1:0] INT_MASK_ADDR = 8'h0c;
    localparam logic [ADDR_W-1:0] STABLE_REFS_ADDR = 8'h10;

    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_CLEAR_BIT = 1;
    localparam int CTRL_PD_BIT = 2;
    localparam logic [2:0] CTRL_RESET = 3'h5;

    localparam int ST_LOCK_BIT = 0;
    localparam int ST_STABLE_BIT = 1;
    localparam int ST_DRESET_BIT = 2;

    localparam int EV_STABLE_BIT = 0;
    localparam int EV_LOST_BIT = 1;
    localparam int EV_W = 2;

    localparam int STABLE_W = 16;
    localparam logic [STABLE_W-1:0] STABLE_REFS_RESET = 16'h0010;

    typedef enum logic [1:0] {
        LOOP_HOLD = 2'b00,
        LOOP_WAIT_REF = 2'b01,
        LOOP_ACQUIRE = 2'b10,
        LOOP_LOCKED = 2'b11
    } loop_state_type;

    function automatic logic [PERIOD_W-1:0] abs_diff(input logic [PERIOD_W-1:0] a,
                                                     input logic [PERIOD_W-1:0] b);
        abs_diff = (a > b) ? a - b : b - a;
    endfunction : abs_diff
endpackage : pll_ctl_pkg

// ==== shared/pll_link_if.sv ====
// Control and clock signals between the loop and the logic that runs it.
// Assumes both ends sit on the same system clock.
`timescale 1ns/1ps
interface pll_link_if;
    import pll_ctl_pkg::*;
    logic reference_clock_in;
    logic loop_enable;
    logic counter_clear;
    logic pd_enable;
    logic [CORE_OUTS-1:0] core_clock;
    logic external_clock_output;
    logic lock;

    modport loop (
        input reference_clock_in, loop_enable, counter_clear, pd_enable,
        output core_clock, external_clock_output, lock
    );
    modport controller (
        output reference_clock_in, loop_enable, counter_clear, pd_enable,
        input core_clock, external_clock_output, lock
    );
endinterface : pll_link_if
